// file: include/pms_pkg.sv
// Constants and types shared by the PLC mode and load sequencer
package pms_pkg;
    // Clock rate and indicator timing
    localparam int unsigned CLK_KHZ      = 125_000;
    localparam int unsigned SU_BLINK_MS  = 3000;
    localparam int unsigned BLINK_MS     = 250;
    localparam int unsigned SU_BLINK_CYC = CLK_KHZ * SU_BLINK_MS;
    localparam int unsigned BLINK_CYC    = CLK_KHZ * BLINK_MS;
    // Power-on settle must outlast the three flops and their agreement stage, or the card is missed
    localparam logic [2:0]  PON_SETTLE   = 3'h6;
    // Register byte addresses
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_CFG  = 8'h04;
    localparam logic [7:0] ADR_BP0  = 8'h08;
    localparam logic [7:0] ADR_BP1  = 8'h0c;
    localparam logic [7:0] ADR_BP2  = 8'h10;
    localparam logic [7:0] ADR_STAT = 8'h14;
    localparam logic [7:0] ADR_DIAG = 8'h18;
    // Control register bits
    localparam int CB_RUN    = 0;
    localparam int CB_RESET  = 1;
    localparam int CB_STORE  = 2;
    localparam int CB_STEP   = 3;
    localparam int CB_RESUME = 4;
    // Configuration fields
    localparam int          CF_DPM   = 0;
    localparam int          CF_ADR   = 1;
    localparam int          CF_MEM   = 16;
    localparam logic [31:0] CFG_MASK = 32'hffff_0003;
    localparam logic [31:0] CFG_RST  = 32'h1000_0000;
    // Breakpoint fields
    localparam int          NUM_BP  = 3;
    localparam int          BP_EN   = 31;
    localparam logic [31:0] BP_MASK = 32'h8000_ffff;
    // Status fields
    localparam int ST_MODE  = 0;
    localparam int ST_INH   = 2;
    localparam int ST_RUNL  = 3;
    localparam int ST_STOPL = 4;
    localparam int ST_CARDL = 5;
    localparam int ST_FLT   = 6;
    localparam int ST_INC   = 7;
    localparam int ST_CBUSY = 8;
    localparam int ST_DLOK  = 9;
    localparam int ST_CARD  = 10;
    // Diagnostic buffer and event identifiers
    localparam int         DG_ID        = 0;
    localparam int         DG_CNT       = 8;
    localparam logic [3:0] DIAG_DEPTH   = 4'h8;
    localparam logic [7:0] EV_LOAD_RST  = 8'h01;
    localparam logic [7:0] EV_LOAD_PON  = 8'h02;
    localparam logic [7:0] EV_STORE     = 8'h03;
    localparam logic [7:0] EV_LOAD_FAIL = 8'h04;
    // Synchroniser lanes
    localparam int SY_CARD = 0;
    localparam int SY_DONE = 1;
    localparam int SY_DL   = 2;
    typedef enum logic [1:0] {M_STOP, M_STARTUP, M_RUN, M_HOLD} pms_mode_e;
    typedef enum logic [2:0] {S_STOP, S_CLR_IN, S_SU, S_CLR_OUT, S_RD_IN, S_MAIN, S_WR_OUT, S_HOLD} pms_st_e;
    typedef enum logic [1:0] {C_IDLE, C_LOAD, C_STORE, C_WAIT} pms_cs_e;
endpackage

// file: design/pms_seq.sv
// Operating-mode, card-load and diagnostic sequencer of the controller CPU
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pms_seq
    import pms_pkg::*;
#(
    parameter logic [31:0] SU_CYC = 32'(SU_BLINK_CYC),
    parameter logic [31:0] BL_CYC = 32'(BLINK_CYC)
) (
    // Clock, reset and enable
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Program engine, same clock
    input  wire logic        su_done,
    input  wire logic        cyc_done,
    input  wire logic        err_stop,
    input  wire logic [15:0] exec_pc,
    output logic             run_startup,
    output logic             run_main,
    output logic             clr_in_img,
    output logic             clr_out_img,
    output logic             rd_in_img,
    output logic             wr_out_img,
    output logic             exec_step,
    output logic             timers_run,
    output logic             cycle_watch_en,
    // Memory card, asynchronous pins
    input  wire logic        card_present,
    input  wire logic        card_done,
    input  wire logic [15:0] card_words,
    output logic             card_rd_req,
    output logic             card_pon_sel,
    output logic             card_wr_req,
    // Download channel
    input  wire logic        dl_req,
    output logic             dl_grant,
    // Indicators
    output logic             output_inhibit,
    output logic             run_led,
    output logic             stop_led,
    output logic             card_activity_led,
    output logic             system_fault_led
);

    // All state of the block
    typedef struct packed {
        pms_st_e          st;
        pms_cs_e          cs;
        logic [2:0]       pon;
        logic [2:0]       s1;
        logic [2:0]       s2;
        logic [2:0]       s3;
        logic [2:0]       sy;
        logic             run_sw;
        logic [31:0]      cfg;
        logic [2:0][31:0] bp;
        logic             fault;
        logic             incomplete;
        logic             pon_sel;
        logic [31:0]      su_cnt;
        logic [31:0]      bl_cnt;
        logic             blink;
        logic             ack;
        logic [31:0]      dat;
        logic [7:0][7:0]  dq;
        logic [2:0]       dwp;
        logic [2:0]       drp;
        logic [3:0]       dcnt;
        logic             inh;
        logic             run_l;
        logic             stop_l;
        logic             card_l;
        logic             su;
        logic             main;
        logic             clr_in;
        logic             clr_out;
        logic             rd_in;
        logic             wr_out;
        logic             step;
        logic             tmr;
        logic             rd_req;
        logic             wr_req;
        logic             dl_ok;
    } pms_state_s;

    localparam pms_state_s RST_S = '{st: S_STOP, cs: C_IDLE, pon: PON_SETTLE, cfg: CFG_RST,
                                     inh: 1'b1, stop_l: 1'b1, default: '0};

    pms_state_s  q;
    pms_state_s  n;
    logic        bp_hit;
    logic [1:0]  bp_num;

    // Byte-lane merge for the writable registers, reserved bits forced low
    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] w,
                                           input logic [3:0] s, input logic [31:0] m);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = w[b*8 +: 8];
            end
        end
        return r & m;
    endfunction

    // Operating mode seen by software for each sequencer state
    function automatic pms_mode_e mode_of(input pms_st_e s);
        case (s)
            S_STOP: begin
                mode_of = M_STOP;
            end
            S_CLR_IN, S_SU: begin
                mode_of = M_STARTUP;
            end
            S_HOLD: begin
                mode_of = M_HOLD;
            end
            default: begin
                mode_of = M_RUN;
            end
        endcase
    endfunction

    // Next-state logic
    always_comb begin
        logic        req;
        logic        wr;
        logic        rd;
        logic        ovr;
        logic        store;
        logic        step;
        logic        resume;
        logic        push;
        logic        pop;
        logic        run_st;
        logic [7:0]  ev;
        logic [31:0] stat;
        n = q;
        req = wb_cyc_i && wb_stb_i && !q.ack;
        wr = req && wb_we_i;
        rd = req && !wb_we_i;
        ovr = 1'b0;
        store = 1'b0;
        step = 1'b0;
        resume = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        ev = 8'h00;
        stat = 32'h0;
        run_st = 1'b0;

        // Three-stage pin synchronisers; a level counts once stages two and three agree
        n.s1 = {dl_req, card_done, card_present};
        n.s2 = q.s1;
        n.s3 = q.s2;
        for (int i = 0; i < 3; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                n.sy[i] = q.s3[i];
            end
        end

        // Breakpoint compare against the engine's program counter
        bp_hit = 1'b0;
        bp_num = 2'h0;
        for (int i = 0; i < NUM_BP; i++) begin
            if (q.bp[i][BP_EN]) begin
                bp_num = bp_num + 2'h1;
            end
            if (q.bp[i][BP_EN] && q.bp[i][15:0] == exec_pc) begin
                bp_hit = 1'b1;
            end
        end

        // Status word, snapshot of the block's own state
        stat[ST_MODE +: 2] = mode_of(q.st);
        stat[ST_INH] = q.inh;
        stat[ST_RUNL] = q.run_l;
        stat[ST_STOPL] = q.stop_l;
        stat[ST_CARDL] = q.card_l;
        stat[ST_FLT] = q.fault;
        stat[ST_INC] = q.incomplete;
        stat[ST_CBUSY] = q.cs != C_IDLE;
        stat[ST_DLOK] = q.dl_ok;
        stat[ST_CARD] = q.sy[SY_CARD];

        // Wishbone slave: one wait state, every address answered
        n.ack = req;
        if (wr) begin
            case (wb_adr_i)
                ADR_CTRL: begin
                    if (wb_sel_i[0]) begin
                        n.run_sw = wb_dat_i[CB_RUN];
                        ovr = wb_dat_i[CB_RESET];
                        store = wb_dat_i[CB_STORE];
                        step = wb_dat_i[CB_STEP];
                        resume = wb_dat_i[CB_RESUME];
                    end
                end
                ADR_CFG: begin
                    n.cfg = wmerge(q.cfg, wb_dat_i, wb_sel_i, CFG_MASK);
                end
                ADR_BP0: begin
                    n.bp[0] = wmerge(q.bp[0], wb_dat_i, wb_sel_i, BP_MASK);
                end
                ADR_BP1: begin
                    n.bp[1] = wmerge(q.bp[1], wb_dat_i, wb_sel_i, BP_MASK);
                end
                ADR_BP2: begin
                    n.bp[2] = wmerge(q.bp[2], wb_dat_i, wb_sel_i, BP_MASK);
                end
                default: begin
                    n.ack = req; // Status and log are read-only: writes acked, dropped
                end
            endcase
        end
        if (rd) begin
            n.dat = 32'h0;
            case (wb_adr_i)
                ADR_CTRL: begin
                    n.dat[CB_RUN] = q.run_sw;
                end
                ADR_CFG: begin
                    n.dat = q.cfg;
                end
                ADR_BP0: begin
                    n.dat = q.bp[0];
                end
                ADR_BP1: begin
                    n.dat = q.bp[1];
                end
                ADR_BP2: begin
                    n.dat = q.bp[2];
                end
                ADR_STAT: begin
                    n.dat = stat;
                end
                ADR_DIAG: begin
                    n.dat[DG_ID +: 8] = q.dq[q.drp];
                    n.dat[DG_CNT +: 4] = q.dcnt;
                    pop = q.dcnt != 4'h0;
                end
                default: begin
                    n.dat = 32'h0;
                end
            endcase
        end

        // Mode sequencer; leaving run never clears images, values are kept
        case (q.st)
            S_STOP: begin
                if (q.run_sw && q.cs == C_IDLE && q.pon == 3'h0 && !q.incomplete) begin
                    n.st = S_CLR_IN;
                end
            end
            S_CLR_IN: begin
                n.st = S_SU;
                n.su_cnt = SU_CYC;
            end
            S_SU: begin
                if (su_done) begin
                    n.st = S_CLR_OUT;
                end
            end
            S_CLR_OUT: begin
                n.st = S_RD_IN;
            end
            S_RD_IN: begin
                n.st = S_MAIN;
            end
            S_MAIN: begin
                if (bp_hit) begin
                    n.st = S_HOLD;
                end else if (cyc_done) begin
                    n.st = S_WR_OUT;
                end
            end
            S_WR_OUT: begin
                n.st = S_RD_IN;
            end
            S_HOLD: begin
                if (resume) begin
                    n.st = S_MAIN;
                end
            end
            default: begin
                n.st = S_STOP;
            end
        endcase
        // Switch to stop wins over every transition, an engine error over all but the start from stop
        if (q.st != S_STOP && (!q.run_sw || err_stop)) begin
            n.st = S_STOP;
        end
        // Single step is refused with more than two breakpoints armed
        n.step = step && q.st == S_HOLD && bp_num <= 2'h2;

        // Start-up blink minimum keeps running into run or stop
        if (q.st != S_CLR_IN && q.su_cnt != 32'h0) begin
            n.su_cnt = q.su_cnt - 32'h1;
        end
        // Single blink enable shared by the run and card activity indicators
        if (q.bl_cnt == 32'h0) begin
            n.bl_cnt = BL_CYC - 32'h1;
            n.blink = !q.blink;
        end else begin
            n.bl_cnt = q.bl_cnt - 32'h1;
        end

        // Card sequencer; power-on load waits for the synchronisers to settle
        if (q.pon > 3'h1) begin
            n.pon = 3'(q.pon - 3'h1);
        end
        case (q.cs)
            C_IDLE: begin
                if (q.pon == 3'h1) begin
                    n.pon = 3'h0;
                    if (q.sy[SY_CARD]) begin
                        n.cs = C_LOAD;
                        n.pon_sel = 1'b1;
                    end
                end else if (ovr && q.st == S_STOP) begin
                    n.fault = 1'b0;
                    n.incomplete = 1'b0;
                    if (q.sy[SY_CARD]) begin
                        n.cs = C_LOAD;
                        n.pon_sel = 1'b0;
                    end
                end else if (store && q.sy[SY_CARD]) begin
                    n.cs = C_STORE;
                    n.pon_sel = 1'b0;
                end
            end
            C_LOAD: begin
                if (q.sy[SY_DONE]) begin
                    n.cs = C_WAIT;
                    push = 1'b1;
                    if (card_words > q.cfg[CF_MEM +: 16]) begin
                        n.fault = 1'b1;
                        n.incomplete = 1'b1;
                        ev = EV_LOAD_FAIL;
                    end else begin
                        ev = q.pon_sel ? EV_LOAD_PON : EV_LOAD_RST;
                    end
                end
            end
            C_STORE: begin
                if (q.sy[SY_DONE]) begin
                    n.cs = C_WAIT;
                    push = 1'b1;
                    ev = EV_STORE;
                end
            end
            C_WAIT: begin
                if (!q.sy[SY_DONE]) begin
                    n.cs = C_IDLE;
                end
            end
            default: begin
                n.cs = C_IDLE;
            end
        endcase

        // Diagnostic log; a full log drops the newest entry
        if (push && q.dcnt != DIAG_DEPTH) begin
            n.dq[q.dwp] = ev;
            n.dwp = q.dwp + 3'h1;
        end else begin
            push = 1'b0;
        end
        if (pop) begin
            n.drp = q.drp + 3'h1;
        end
        n.dcnt = 4'(q.dcnt + {3'h0, push} - {3'h0, pop});

        // Registered outputs follow the next state so they change with it
        run_st = n.st inside {S_CLR_OUT, S_RD_IN, S_MAIN, S_WR_OUT};
        n.inh = !run_st;
        n.su = n.st == S_SU;
        n.main = n.st == S_MAIN;
        n.clr_in = n.st == S_CLR_IN;
        n.clr_out = n.st == S_CLR_OUT;
        n.rd_in = n.st == S_RD_IN;
        n.wr_out = n.st == S_WR_OUT;
        n.tmr = run_st;
        n.stop_l = n.st == S_STOP || n.st == S_HOLD;
        if (n.st inside {S_CLR_IN, S_SU, S_HOLD} || n.su_cnt != 32'h0) begin
            n.run_l = n.blink;
        end else begin
            n.run_l = run_st;
        end
        n.card_l = (n.cs == C_LOAD || n.cs == C_STORE) && n.blink;
        n.rd_req = n.cs == C_LOAD;
        n.wr_req = n.cs == C_STORE;
        n.dl_ok = n.sy[SY_DL] && n.cfg[CF_DPM] && n.cfg[CF_ADR];
    end

    // State register; the enable freezes everything
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RST_S;
        end else if (ce) begin
            q <= n;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;
    assign run_startup = q.su;
    assign run_main = q.main;
    assign clr_in_img = q.clr_in;
    assign clr_out_img = q.clr_out;
    assign rd_in_img = q.rd_in;
    assign wr_out_img = q.wr_out;
    assign exec_step = q.step;
    assign timers_run = q.tmr;
    assign cycle_watch_en = q.tmr; // Start-up is never supervised
    assign card_rd_req = q.rd_req;
    assign card_pon_sel = q.pon_sel;
    assign card_wr_req = q.wr_req;
    assign dl_grant = q.dl_ok;
    assign output_inhibit = q.inh;
    assign run_led = q.run_l;
    assign stop_led = q.stop_l;
    assign card_activity_led = q.card_l;
    assign system_fault_led = q.fault;

    // Checks on the sequencer
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_n);

    stop_outputs_a: assert property (q.st == S_STOP |-> q.inh && !q.main && !q.su && q.stop_l)
        else $error("stop mode drives outputs or runs code");
    su_inhibit_a: assert property (q.su |-> q.inh && !q.stop_l && !q.tmr)
        else $error("start-up releases outputs or lights stop");
    su_blink_a: assert property (ce && q.st == S_CLR_IN |=> q.su_cnt == SU_CYC && q.st != S_RD_IN)
        else $error("start-up blink minimum not loaded");
    su_to_run_a: assert property (ce && q.su && su_done && q.run_sw && !err_stop |=> q.clr_out ##0 !q.inh)
        else $error("start-up end did not enter run");
    run_outputs_a: assert property (q.main |-> !q.inh && q.run_l == (q.su_cnt == 32'h0 ? 1'b1 : q.blink))
        else $error("run mode indicator or inhibit wrong");
    bp_hold_a: assert property (ce && q.main && bp_hit && q.run_sw && !err_stop |=> q.st == S_HOLD)
        else $error("breakpoint did not enter hold");
    hold_outputs_a: assert property (q.st == S_HOLD |-> q.inh && q.stop_l && !q.tmr && !q.main)
        else $error("hold mode outputs wrong");
    load_fault_a: assert property (ce && q.cs == C_LOAD && q.sy[SY_DONE] && card_words > q.cfg[CF_MEM +: 16]
                                   |=> q.fault && q.incomplete && q.cs == C_WAIT)
        else $error("oversized image not flagged");
    card_led_a: assert property (!(q.cs inside {C_LOAD, C_STORE}) |-> !q.card_l)
        else $error("card indicator lit while card idle");
    grant_a: assert property (q.dl_ok |-> q.cfg[CF_DPM] && q.cfg[CF_ADR])
        else $error("download granted without master role and address");
    log_write_a: assert property (ce && q.cs == C_STORE && q.sy[SY_DONE] && q.dcnt == 4'h0
                                  |=> q.dcnt == 4'h1 && q.dq[$past(q.dwp)] == EV_STORE)
        else $error("card write not logged");

    run_seen_c: cover property (mode_of(q.st) == M_RUN ##1 q.wr_out);
    hold_seen_c: cover property (mode_of(q.st) == M_HOLD ##1 q.step);
    load_seen_c: cover property (q.rd_req ##[1:40] q.cs == C_WAIT);
    store_seen_c: cover property (q.wr_req ##[1:40] q.dcnt != 4'h0);

endmodule
`default_nettype wire

// file: tb/pms_card_model.sv
// Behavioural memory card answering load and store requests
`timescale 1ns/1ps
`default_nettype none
module pms_card_model (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Requests from the sequencer
    input  wire logic        card_rd_req,
    input  wire logic        card_wr_req,
    // Image size held in the card root
    input  wire logic [15:0] img_words,
    // Answer to the sequencer
    output logic             card_done,
    output logic [15:0]      card_words
);
    logic [4:0] wait_q;
    // Slow answer, then done held until the request drops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q    <= 5'h00;
            card_done <= 1'b0;
        end else if ((card_rd_req | card_wr_req) && !card_done) begin
            wait_q <= wait_q + 5'h01;
            if (wait_q == 5'h13) begin
                card_done <= 1'b1;
                wait_q    <= 5'h00;
            end
        end else if (!(card_rd_req | card_wr_req)) begin
            card_done <= 1'b0;
        end
    end
    // Size only valid with done; scrambled otherwise so no stale value passes
    assign card_words = card_done ? img_words : ~img_words;
endmodule
`default_nettype wire

// file: tb/plc_mode_and_load_sequencer_tb_top.sv
// Self-checking bench for the mode and load sequencer
`timescale 1ns/1ps
`default_nettype none
module plc_mode_and_load_sequencer_tb_top;
    import pms_pkg::*;
    logic mclk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, su_done = 0, cyc_done = 0;
    logic card_present = 1, dl_req = 0, card_done, card_rd_req, card_pon_sel, card_wr_req, dl_grant;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic [15:0] exec_pc = 16'h0, card_words, img_words = 16'h0100;
    logic wb_ack_o, run_startup, run_main, clr_in_img, clr_out_img, rd_in_img, wr_out_img, exec_step;
    logic timers_run, cycle_watch_en, output_inhibit, run_led, stop_led, card_activity_led, system_fault_led;
    int failures = 0, comparisons = 0;
    // Short start-up and blink counts keep the run brief
    pms_seq #(.SU_CYC(32'h28), .BL_CYC(32'h4)) dut (.ce(1'b1), .err_stop(1'b0), .*);
    pms_card_model card (.*);
    always #4 mclk = ~mclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic single Wishbone cycle; only the watchdog ends a hung wait for ack
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        do begin
            @(posedge mclk);
        end while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    // Read status until the masked field settles on the wanted value
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do begin
            wb(0, ADR_STAT, 0, q);
            n++;
        end while ((q & m) !== v && n < 200);
        chk(q & m, v);
    endtask
    // One card access from busy to idle, then the logged event
    task automatic card_op(input logic [31:0] c, input logic pon, input logic [31:0] ev);
        if (c != 0) wb(1, ADR_CTRL, c, q);
        poll(32'h100, 32'h100);
        chk(card_rd_req ^ card_wr_req, 1'b1);
        chk(card_pon_sel, pon);
        poll(32'h100, 32'h0);
        wb(0, ADR_DIAG, 0, q);
        chk(q, ev);
    endtask
    task automatic final_report;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1;
        chk({output_inhibit, stop_led, run_led}, 3'b110);
        wb(0, ADR_CFG, 0, q);
        chk(q, CFG_RST);
        wb(0, 8'h1c, 0, q);
        chk(q, 32'h0);
        card_op(0, 1, 32'h102);
        wb(1, ADR_CTRL, 32'h1, q);
        poll(32'h3, 32'h1);
        chk({output_inhibit, stop_led, cycle_watch_en, run_startup}, 4'b1001);
        su_done <= 1;
        @(posedge mclk);
        su_done <= 0;
        poll(32'h3, 32'h2);
        chk({output_inhibit, stop_led}, 2'b00);
        // Let the sequence settle in the main routine, then end one pass
        repeat (2) @(posedge mclk);
        chk({run_main, timers_run, rd_in_img}, 3'b110);
        cyc_done <= 1;
        @(posedge mclk);
        cyc_done <= 0;
        @(posedge mclk);
        chk({run_main, wr_out_img}, 2'b01);
        wb(1, ADR_BP0, 32'h8000_0010, q);
        exec_pc <= 16'h0010;
        poll(32'h3, 32'h3);
        chk({output_inhibit, stop_led, timers_run}, 3'b110);
        wb(1, ADR_CTRL, 32'h9, q);
        chk(exec_step, 1'b1);
        exec_pc <= 16'h0000;
        wb(1, ADR_CTRL, 32'h11, q);
        poll(32'h3, 32'h2);
        wb(1, ADR_CTRL, 32'h0, q);
        poll(32'h3, 32'h0);
        chk({output_inhibit, stop_led}, 2'b11);
        card_op(32'h2, 0, 32'h101);
        card_op(32'h4, 0, 32'h103);
        chk(card_activity_led, 1'b0);
        img_words <= 16'h2000;
        card_op(32'h2, 0, 32'h104);
        chk(system_fault_led, 1'b1);
        dl_req <= 1;
        wb(1, ADR_CFG, 32'h3, q);
        poll(32'h200, 32'h200);
        chk(dl_grant, 1'b1);
        final_report();
    end
    // Watchdog well beyond the expected length of the sequence
    initial begin
        repeat (30000) @(posedge mclk);
        failures++;
        final_report();
    end
endmodule
`default_nettype wire
